// ---- common/edge_menu_map.svh ----
// Constants of the card-edge menu and status controller: offsets, fields, resets, timings.
// Assumes a 25 MHz core clock and an APB slave with 32-bit data.
// Functional notes
// - Warnings flash on the display and replace any menu text shown.
// - Only the highest warning shows: laser fault, then link absence, then healthy.
// - A press while a warning shows only hides it; presses and toggles reach the menu again once it is hidden.
// - Laser end-of-life raises the laser fault warning.
// - Link down raises link absence; link up without problems shows healthy.
// - Optical power reads as signed whole dBm in 1 dBm steps from -40.
// - Pressing on the power item at level one shows the power readout.
// - Power below -40 dBm shows the low text instead of a number.
// - Power above the maximum shows the over-range text instead of a number.
// - One LED per channel: four balanced, then serial, then timecode last; 8 or 13.
// - Combined mode lights an LED on input or output activity.
// - Input mode lights an LED on input data transitions.
// - Output mode lights an LED on output data transitions.
// - General input or output modes light an LED while that line is low.
// - In the mode menu the toggle steps modes; a press commits and returns to level one.
// - Reset indicator mode is combined activity.
// - Each of four balanced channels holds point-to-point or multidrop.
// - Line type is stored per channel; toggle picks the channel, press confirms.
// - In the type item toggle flips type; press commits and returns to level three.
// - Back at level three returns to level two, changing nothing.
// - Reset line type of every balanced channel is point-to-point.
// - A press on an item with a sub-level descends a level; the toggle moves through the current level.
// - Latest selections are kept in non-volatile storage across power loss.
// - The data rate item is offered only while the channel is multidrop.
`ifndef EDGE_MENU_MAP_SVH
`define EDGE_MENU_MAP_SVH
`define CLK_KHZ 25000
`define DEBOUNCE_US 10000
`define STRETCH_US 50000
`define DEBOUNCE_CYC ((`DEBOUNCE_US * `CLK_KHZ + 999) / 1000)
`define STRETCH_CYC ((`STRETCH_US * `CLK_KHZ + 999) / 1000)
`define PWR_MIN_DBM (-40)
`define PWR_MAX_DBM 5
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define CTRL_MODE_LSB 0
`define CTRL_TYPE_LSB 4
`define ST_WARN_LSB 0
`define ST_SHOWN_BIT 2
`define ST_PWR_LSB 8
`define ST_MENU_LSB 16
`define MODE_RESET 3'h0
`define TYPE_RESET 4'h0
`endif

// ---- common/edge_menu_pkg.sv ----
// Types of the card-edge menu and status controller.
// Assumes edge_menu_map.svh supplies all numeric constants.
package edge_menu_pkg;
  typedef enum logic [2:0] {
    S_L1 = 3'b000, S_PWR = 3'b001, S_MODE = 3'b010,
    S_CHAN = 3'b011, S_L3 = 3'b100, S_TYPE = 3'b101
  } menu_state_type;
  typedef enum logic [2:0] {
    M_COMBINED = 3'b000, M_INPUT = 3'b001, M_OUTPUT = 3'b010,
    M_GEN_IN = 3'b011, M_GEN_OUT = 3'b100
  } led_mode_type;
  typedef enum logic [1:0] {
    W_OK = 2'b00, W_LINK = 2'b01, W_LASER = 2'b10
  } warn_type;
  typedef enum logic [4:0] {
    T_OK, T_LINK, T_LASER, T_PWR, T_STAT, T_CTRL, T_NUM, T_LOW, T_OVER,
    T_BOTH, T_IN, T_OUT, T_GEN_IN, T_GEN_OUT, T_CHAN, T_BACK, T_TYPE, T_RATE,
    T_P2P, T_MDROP
  } text_type;
  typedef struct packed {
    text_type text;
    logic signed [7:0] value;
    logic flash;
  } display_type;
  typedef struct packed {
    logic laser_eol;
    logic link_up;
    logic input_fault;
  } link_status_type;
endpackage

// ---- hdl/edge_menu_ctrl.sv ----
// Card-edge menu, warning display, activity LEDs and line type store, with an APB slave.
// Assumes pushbutton, toggle and channel data arrive asynchronously on pins; link status,
// power and the non-volatile store run on core_clk.
`timescale 1ns/1ps
`include "edge_menu_map.svh"
module edge_menu_ctrl #(
  parameter int LED_COUNT = 8,
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int STRETCH_CYC = `STRETCH_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operator controls, raw pins.
  input wire logic button_pin,
  input wire logic toggle_up_pin,
  input wire logic toggle_down_pin,
  // Link status and power reading.
  input wire edge_menu_pkg::link_status_type link_status,
  input wire logic signed [7:0] power_dbm,
  // Channel data and general lines, raw pins.
  input wire logic [LED_COUNT-1:0] chan_in_pin,
  input wire logic [LED_COUNT-1:0] chan_out_pin,
  input wire logic [LED_COUNT-1:0] gen_line_n_pin,
  // Non-volatile store.
  input wire logic nv_load,
  input wire logic [6:0] nv_load_data,
  output logic nv_store,
  output logic [6:0] nv_store_data,
  // Display, LEDs and line types.
  output edge_menu_pkg::display_type display,
  output logic [LED_COUNT-1:0] led,
  output logic [3:0] multidrop
);
  import edge_menu_pkg::*;

  localparam bit GPIO_VARIANT = (LED_COUNT == 13);
  localparam int DW = $clog2(DEBOUNCE_CYC + 1);
  localparam int SW = $clog2(STRETCH_CYC + 1);
  localparam logic [2:0] MODE_LAST = GPIO_VARIANT ? 3'h4 : 3'h2;
  localparam logic signed [7:0] PWR_MIN = 8'(`PWR_MIN_DBM);
  localparam logic signed [7:0] PWR_MAX = 8'(`PWR_MAX_DBM);

  // Steps a menu index up or down with wrap-around.
  function automatic logic [2:0] step(input logic [2:0] v, input logic [2:0] last,
                                      input logic up);
    if (up) begin
      step = (v == last) ? 3'h0 : v + 3'h1;
    end else begin
      step = (v == 3'h0) ? last : v - 3'h1;
    end
  endfunction

  // Two-stage synchronisers for every pin; a third stage feeds edge detection only.
  logic [2:0] ctl_s1_reg, ctl_s2_reg;
  logic [LED_COUNT-1:0] in_s1_reg, in_s2_reg, in_s3_reg;
  logic [LED_COUNT-1:0] out_s1_reg, out_s2_reg, out_s3_reg;
  logic [LED_COUNT-1:0] gen_s1_reg, gen_s2_reg;
  always_ff @(posedge core_clk) begin
    ctl_s1_reg <= {toggle_down_pin, toggle_up_pin, button_pin};
    ctl_s2_reg <= ctl_s1_reg;
    in_s1_reg <= chan_in_pin;
    in_s2_reg <= in_s1_reg;
    in_s3_reg <= in_s2_reg;
    out_s1_reg <= chan_out_pin;
    out_s2_reg <= out_s1_reg;
    out_s3_reg <= out_s2_reg;
    gen_s1_reg <= gen_line_n_pin;
    gen_s2_reg <= gen_s1_reg;
  end

  // Debounce: a level must stay put for DEBOUNCE_CYC cycles before it is accepted, and
  // only the accepted rising edge makes a one-cycle event, so bounce never repeats it.
  logic [2:0] ctl_stable_reg, ctl_event;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_deb
      logic [DW-1:0] cnt_reg;
      logic [DW-1:0] cnt_next;
      logic stable_reg;
      assign ctl_stable_reg[g] = stable_reg;
      assign cnt_next = (ctl_s2_reg[g] == ctl_stable_reg[g]) ? '0 : cnt_reg + 1'b1;
      assign ctl_event[g] = ctl_s2_reg[g] && !ctl_stable_reg[g]
                            && (cnt_reg == DW'(DEBOUNCE_CYC - 1));
      always_ff @(posedge core_clk) begin
        if (srst) begin
          cnt_reg <= '0;
          stable_reg <= 1'b0;
        end else if (cnt_reg == DW'(DEBOUNCE_CYC - 1)) begin
          cnt_reg <= '0;
          stable_reg <= ctl_s2_reg[g];
        end else begin
          cnt_reg <= cnt_next;
        end
      end
    end
  endgenerate
  wire press = ctl_event[0];
  wire tog_up = ctl_event[1];
  wire tog_dn = ctl_event[2] && !ctl_event[1];
  wire tog = tog_up || tog_dn;

  // Warning priority: laser fault over link absence over healthy.
  warn_type warn;
  assign warn = link_status.laser_eol ? W_LASER :
                !link_status.link_up ? W_LINK : W_OK;
  wire healthy = (warn == W_OK) && !link_status.input_fault;

  // A warning is shown until pressed away or cleared; a rise to a new warning re-arms it, and the
  // re-arm wins over a press in the same cycle so a fresh fault is never hidden.
  warn_type warn_last_reg;
  logic warn_shown_reg;
  wire warn_rise = (warn != W_OK) && (warn != warn_last_reg);
  wire warn_hide = press && warn_shown_reg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      warn_last_reg <= W_OK;
      warn_shown_reg <= 1'b0;
    end else begin
      warn_last_reg <= warn;
      if (warn_rise) begin
        warn_shown_reg <= 1'b1;
      end else if (warn_hide || warn == W_OK) begin
        warn_shown_reg <= 1'b0;
      end
    end
  end

  // Menu state. Presses consumed by hiding a warning do nothing else.
  menu_state_type state_reg, state_next;
  logic [2:0] sel_reg, sel_next, chan_reg, chan_next;
  led_mode_type mode_reg;
  logic [3:0] type_reg;
  wire act_press = press && !warn_shown_reg;
  wire act_tog = tog && !warn_shown_reg;
  wire chan_md = type_reg[chan_reg[1:0]];
  wire [2:0] l3_next = step(sel_reg, 3'h2, tog_up);
  wire [2:0] l3_skip = (l3_next == 3'h1 && !chan_md) ? step(l3_next, 3'h2, tog_up) : l3_next;
  wire commit_mode = (state_reg == S_MODE) && act_press;
  wire commit_type = (state_reg == S_TYPE) && act_press;

  // Next-state decode; the mode and type edits keep their shown value in sel_reg.
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    chan_next = chan_reg;
    unique case (state_reg)
      S_L1: begin
        if (act_tog) begin
          sel_next = step(sel_reg, 3'h3, tog_up);
        end else if (act_press) begin
          unique case (sel_reg[1:0])
            2'h1: state_next = S_PWR;
            2'h2: begin
              state_next = S_MODE;
              sel_next = mode_reg;
            end
            2'h3: begin
              state_next = S_CHAN;
              sel_next = 3'h0;
            end
            default: state_next = S_L1;
          endcase
        end
      end
      S_PWR: begin
        if (act_press) begin
          state_next = S_L1;
        end
      end
      S_MODE: begin
        if (act_tog) begin
          sel_next = step(sel_reg, MODE_LAST, tog_up);
        end else if (act_press) begin
          state_next = S_L1;
          sel_next = 3'h2;
        end
      end
      S_CHAN: begin
        if (act_tog) begin
          sel_next = step(sel_reg, 3'h4, tog_up);
        end else if (act_press && sel_reg == 3'h4) begin
          state_next = S_L1;
          sel_next = 3'h3;
        end else if (act_press) begin
          state_next = S_L3;
          chan_next = sel_reg;
          sel_next = 3'h0;
        end
      end
      S_L3: begin
        if (act_tog) begin
          sel_next = l3_skip;
        end else if (act_press && sel_reg == 3'h2) begin
          state_next = S_CHAN;
          sel_next = chan_reg;
        end else if (act_press && sel_reg == 3'h0) begin
          state_next = S_TYPE;
          sel_next = {2'h0, chan_md};
        end
      end
      S_TYPE: begin
        if (act_tog) begin
          sel_next = {2'h0, !sel_reg[0]};
        end else if (act_press) begin
          state_next = S_L3;
          sel_next = 3'h0;
        end
      end
      default: state_next = S_L1;
    endcase
  end

  // APB decode; the slave answers in the access cycle with no wait.
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == `OFS_CTRL);
  wire hit_stat = (paddr == `OFS_STATUS);
  wire sw_ctrl = apb_wr && hit_ctrl;
  wire [2:0] sw_mode = pwdata[`CTRL_MODE_LSB +: 3];
  wire sw_mode_ok = (sw_mode <= MODE_LAST);

  // Settings: menu commits, software writes and a store restore all land here.
  logic save_reg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= S_L1;
      sel_reg <= 3'h0;
      chan_reg <= 3'h0;
      mode_reg <= led_mode_type'(`MODE_RESET);
      type_reg <= `TYPE_RESET;
      save_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      chan_reg <= chan_next;
      save_reg <= commit_mode || commit_type || sw_ctrl;
      if (nv_load) begin
        mode_reg <= led_mode_type'(nv_load_data[2:0]);
        type_reg <= nv_load_data[6:3];
      end else if (commit_mode) begin
        mode_reg <= led_mode_type'(sel_reg);
      end else if (commit_type) begin
        type_reg[chan_reg[1:0]] <= sel_reg[0];
      end else if (sw_ctrl) begin
        if (sw_mode_ok) begin
          mode_reg <= led_mode_type'(sw_mode);
        end
        type_reg <= pwdata[`CTRL_TYPE_LSB +: 4];
      end
    end
  end

  // The store sees the settings word one cycle after any change is committed.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nv_store <= 1'b0;
      nv_store_data <= {`TYPE_RESET, `MODE_RESET};
    end else begin
      nv_store <= save_reg;
      nv_store_data <= {type_reg, mode_reg};
    end
  end
  assign multidrop = type_reg;

  // Activity: each transition reloads a per-LED hold counter, so even a single edge
  // stays visible for STRETCH_CYC cycles; the cost is two counters per LED, one for input and one for output.
  logic [LED_COUNT-1:0] in_act, out_act;
  generate
    for (g = 0; g < LED_COUNT; g++) begin : gen_led
      logic [SW-1:0] in_cnt_reg, out_cnt_reg;
      wire in_edge = in_s2_reg[g] ^ in_s3_reg[g];
      wire out_edge = out_s2_reg[g] ^ out_s3_reg[g];
      assign in_act[g] = (in_cnt_reg != '0);
      assign out_act[g] = (out_cnt_reg != '0);
      always_ff @(posedge core_clk) begin
        if (srst) begin
          in_cnt_reg <= '0;
          out_cnt_reg <= '0;
        end else begin
          in_cnt_reg <= in_edge ? SW'(STRETCH_CYC) : (in_act[g] ? in_cnt_reg - 1'b1 : '0);
          out_cnt_reg <= out_edge ? SW'(STRETCH_CYC) : (out_act[g] ? out_cnt_reg - 1'b1 : '0);
        end
      end
    end
  endgenerate

  // LED select per mode; LED order follows the channel order at the pins.
  logic [LED_COUNT-1:0] led_next;
  always_comb begin
    unique case (mode_reg)
      M_COMBINED: led_next = in_act | out_act;
      M_INPUT: led_next = in_act;
      M_OUTPUT: led_next = out_act;
      M_GEN_IN, M_GEN_OUT: led_next = GPIO_VARIANT ? ~gen_s2_reg : '0;
      default: led_next = '0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      led <= '0;
    end else begin
      led <= led_next;
    end
  end

  // Display text; a shown warning flashes over anything else.
  wire pwr_low = (power_dbm < PWR_MIN);
  wire pwr_over = (power_dbm > PWR_MAX);
  text_type menu_text;
  always_comb begin
    unique case (state_reg)
      S_L1: menu_text = (sel_reg == 3'h0) ? (healthy ? T_OK : (warn == W_LASER ? T_LASER :
                        (warn == W_LINK ? T_LINK : T_BACK))) :
                        (sel_reg == 3'h1) ? T_PWR : (sel_reg == 3'h2) ? T_STAT : T_CTRL;
      S_PWR: menu_text = pwr_low ? T_LOW : (pwr_over ? T_OVER : T_NUM);
      S_MODE: menu_text = text_type'(5'(T_BOTH) + 5'(sel_reg));
      S_CHAN: menu_text = (sel_reg == 3'h4) ? T_BACK : T_CHAN;
      S_L3: menu_text = (sel_reg == 3'h0) ? T_TYPE : (sel_reg == 3'h1) ? T_RATE : T_BACK;
      S_TYPE: menu_text = sel_reg[0] ? T_MDROP : T_P2P;
      default: menu_text = T_OK;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      display <= '{text: T_OK, value: 8'sh00, flash: 1'b0};
    end else if (warn_shown_reg) begin
      display.text <= (warn == W_LASER) ? T_LASER : T_LINK;
      display.value <= 8'sh00;
      display.flash <= 1'b1;
    end else begin
      display.text <= menu_text;
      display.value <= (state_reg == S_PWR) ? power_dbm :
                       (state_reg == S_CHAN) ? 8'(sel_reg) + 8'sh01 : 8'sh00;
      display.flash <= 1'b0;
    end
  end

  // APB read mux and answer; unmapped addresses read zero with an error.
  logic [31:0] rd_word;
  assign rd_word = hit_ctrl ? {24'h0, type_reg, 1'b0, mode_reg} :
                   hit_stat ? {13'h0, state_reg, power_dbm, 5'h0,
                               warn_shown_reg, warn} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || hit_stat);
  // Read data is captured in the setup cycle, so the access cycle shows a flop and still
  // needs no wait state; outside a read access the bus returns to zero.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end else begin
      prdata <= 32'h0;
    end
  end

  // Checks on the guarded logic.
  debounce_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    press |=> !press) else $error("press lasted more than one cycle");
  warn_priority_a: assert property (@(posedge core_clk) disable iff (srst)
    (warn_shown_reg && link_status.laser_eol) |=> display.text == T_LASER && display.flash)
    else $error("laser fault not shown first");
  warn_hide_a: assert property (@(posedge core_clk) disable iff (srst)
    (warn_hide && !warn_rise) |=> !warn_shown_reg && state_reg == $past(state_reg))
    else $error("press did not only hide the warning");
  pwr_low_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == S_PWR && !warn_shown_reg && power_dbm < PWR_MIN) |=> display.text == T_LOW)
    else $error("low reading not shown");
  mode_commit_a: assert property (@(posedge core_clk) disable iff (srst)
    (commit_mode && !nv_load) |=> mode_reg == $past(sel_reg) && state_reg == S_L1)
    else $error("mode commit wrong");
  type_commit_a: assert property (@(posedge core_clk) disable iff (srst)
    (commit_type && !nv_load) |=> state_reg == S_L3 ##1 nv_store)
    else $error("type commit did not return or store");
  back_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == S_L3 && act_press && sel_reg == 3'h2 && !sw_ctrl && !nv_load)
    |=> state_reg == S_CHAN && $stable(type_reg)) else $error("back changed a setting");
  rate_hidden_a: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == S_L3 && sel_reg == 3'h1) |-> chan_md)
    else $error("rate item offered on point-to-point");
  led_input_a: assert property (@(posedge core_clk) disable iff (srst)
    (mode_reg == M_INPUT && in_s2_reg[0] != in_s3_reg[0]) |=> ##1 led[0])
    else $error("input transition did not light its led");
endmodule // edge_menu_ctrl

// ---- verif/card_edge_menu_status_control_test.sv ----
// Self-checking bench for the card-edge menu controller, 8-LED variant.
// Assumes short debounce and stretch counts so that menu walks stay brief.
`timescale 1ns/1ps
`include "edge_menu_map.svh"
module card_edge_menu_status_control_test;
  import edge_menu_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, nv_store, button_pin, toggle_up_pin, toggle_down_pin;
  logic nv_load = 1'b0;
  link_status_type link_status = 3'h2;
  logic signed [7:0] power_dbm = 8'h00;
  logic signed [7:0] p;
  logic [7:0] chan_in_pin = 8'h00;
  logic [7:0] chan_out_pin = 8'h00;
  logic [7:0] gen_line_n_pin = 8'hFF;
  logic [7:0] led;
  logic [6:0] nv_load_data = 7'h00;
  logic [6:0] nv_store_data;
  logic [3:0] multidrop;
  display_type display;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h7F32;
  int i, m, k;

  // 25 MHz core clock.
  always #20 core_clk = ~core_clk;

  edge_menu_ctrl #(.LED_COUNT(8), .DEBOUNCE_CYC(4), .STRETCH_CYC(8)) dut (.core_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .button_pin,
    .toggle_up_pin, .toggle_down_pin, .link_status, .power_dbm, .chan_in_pin, .chan_out_pin,
    .gen_line_n_pin, .nv_load, .nv_load_data, .nv_store, .nv_store_data, .display, .led,
    .multidrop);

  operator_panel op (.core_clk, .button_pin, .toggle_up_pin, .toggle_down_pin);

  // Expected display text of the power view.
  function automatic text_type pwr_text(input logic signed [7:0] v);
    if (v < `PWR_MIN_DBM) return T_LOW;
    if (v > `PWR_MAX_DBM) return T_OVER;
    return T_NUM;
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // The request is held until pready is seen high at the closing edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
  endtask

  task automatic moves(input int which, input int n);
    repeat (n) op.move(which, 12);
  endtask

  task automatic menu(input menu_state_type s);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[18:16], s);
  endtask

  // A hang anywhere ends the run as a mismatch.
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    report_and_stop;
  end

  // Main sequence.
  initial begin
    do_reset;
    chk(display, {T_OK, 8'h00, 1'b0});
    chk(multidrop, 4'h0);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    for (i = 0; i < 4; i++) begin
      m = $random(seed) & 15;
      apb(1'b1, `OFS_CTRL, (m << `CTRL_TYPE_LSB) | (i % 3));
      tick(1);
      chk(multidrop, m);
      tick(1);
      chk(nv_store, 1'b1);
      chk(nv_store_data, (m << 3) | (i % 3));
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(rd, (m << `CTRL_TYPE_LSB) | (i % 3));
    end
    apb(1'b1, `OFS_CTRL, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h3);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h2);
    $display("end of register test");
    do_reset;
    link_status <= 3'h6;
    tick(4);
    chk(display.text, T_LASER);
    chk(display.flash, 1'b1);
    link_status <= 3'h4;
    tick(4);
    chk(display.text, T_LASER);
    link_status <= 3'h0;
    tick(4);
    chk(display.text, T_LINK);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[2:0], {1'b1, W_LINK});
    op.move(0, 12);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[2:0], {1'b0, W_LINK});
    chk(display.flash, 1'b0);
    link_status <= 3'h2;
    tick(4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[1:0], W_OK);
    chk(display.text, T_OK);
    $display("end of warning test");
    do_reset;
    op.move(0, 2);
    menu(S_L1);
    moves(1, 1);
    moves(0, 1);
    menu(S_PWR);
    for (i = 0; i < 6; i++) begin
      case (i)
        0: p = -8'sd41;
        1: p = -8'sd40;
        2: p = 8'sd5;
        3: p = 8'sd6;
        4: p = -8'sd128;
        default: p = 8'($random(seed) % 40);
      endcase
      @(posedge core_clk);
      power_dbm <= p;
      tick(4);
      chk(display.text, pwr_text(p));
      if (pwr_text(p) == T_NUM) chk(display.value, p);
    end
    $display("end of power test");
    do_reset;
    moves(1, 2);
    moves(0, 1);
    menu(S_MODE);
    moves(1, 1);
    moves(0, 1);
    menu(S_L1);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd[2:0], M_INPUT);
    for (m = 0; m < 3; m++) begin
      apb(1'b1, `OFS_CTRL, m);
      k = (m == 0) ? 7 : (m == 1) ? 0 : ($random(seed) & 7);
      chan_in_pin[k] <= 1'b1;
      tick(6);
      chk(led[k], m != M_OUTPUT);
      chan_in_pin <= 8'h00;
      tick(30);
      chk(led, 8'h00);
      chan_out_pin[k] <= 1'b1;
      tick(6);
      chk(led[k], m != M_INPUT);
      chan_out_pin <= 8'h00;
      tick(30);
    end
    $display("end of indicator test");
    do_reset;
    moves(1, 3);
    moves(0, 1);
    menu(S_CHAN);
    moves(1, 2);
    moves(0, 2);
    menu(S_TYPE);
    moves(1, 1);
    moves(0, 1);
    menu(S_L3);
    chk(multidrop, 4'h4);
    chk(nv_store_data, 7'h20);
    moves(1, 2);
    moves(0, 1);
    menu(S_CHAN);
    chk(multidrop, 4'h4);
    moves(2, 1);
    moves(0, 1);
    moves(1, 2);
    moves(0, 1);
    menu(S_TYPE);
    @(posedge core_clk);
    nv_load <= 1'b1;
    nv_load_data <= 7'h4A;
    @(posedge core_clk);
    nv_load <= 1'b0;
    tick(2);
    chk(multidrop, 4'h9);
    $display("end of line type test");
    report_and_stop;
  end
endmodule // card_edge_menu_status_control_test

// ---- verif/operator_panel.sv ----
// Operator panel model: pushbutton and two-way toggle switch as raw pins.
// Assumes the controller synchronises and debounces these pins on core_clk.
`timescale 1ns/1ps
module operator_panel #(
  parameter int REST_CYC = 12
) (
  // Clock.
  input wire logic core_clk,
  // Raw operator pins.
  output logic button_pin,
  output logic toggle_up_pin,
  output logic toggle_down_pin
);
  // Released contacts are pulled low, so every pin rests low.
  initial begin
    button_pin = 1'b0;
    toggle_up_pin = 1'b0;
    toggle_down_pin = 1'b0;
  end
  // One movement: 0 press, 1 toggle up, 2 toggle down, held cyc cycles, then rest.
  // A short hold models contact bounce that must not count as a movement.
  task automatic move(input int which, input int cyc);
    @(posedge core_clk);
    button_pin <= (which == 0);
    toggle_up_pin <= (which == 1);
    toggle_down_pin <= (which == 2);
    repeat (cyc) @(posedge core_clk);
    button_pin <= 1'b0;
    toggle_up_pin <= 1'b0;
    toggle_down_pin <= 1'b0;
    repeat (REST_CYC) @(posedge core_clk);
  endtask
endmodule // operator_panel
